// ### rtl/timer16_pkg.sv
// Constants, field layouts and carrier types of the 16-bit compare timer.
// Assumes one clock domain and an AXI4-Lite master on the register side.

package timer16_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_CMPA  = 8'h08;
  localparam logic [7:0] OFS_CMPB  = 8'h0c;
  localparam logic [7:0] OFS_CAPT  = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_PORT  = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FORCE_A_BIT = 8;
  localparam int FORCE_B_BIT = 9;
  localparam int DIR_LSB     = 2;
  localparam int STATE_LSB   = 4;

  // ----------------------------------------------------------------
  // Values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam logic [3:0]  WGM_NORMAL = 4'h0;
  localparam logic [3:0]  WGM_CTC_A  = 4'h4;
  localparam logic [3:0]  WGM_CTC_I  = 4'hc;
  localparam logic [1:0]  COM_NONE   = 2'h0;
  localparam logic [1:0]  COM_TOGGLE = 2'h1;
  localparam logic [1:0]  COM_CLEAR  = 2'h2;
  localparam logic [1:0]  COM_SET    = 2'h3;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] compare_output_mode_b;
    logic [1:0] compare_output_mode_a;
    logic [3:0] waveform_mode_select;
  } ctrl_t;

  typedef struct packed {
    logic capture_flag;
    logic compare_match_flag_b;
    logic compare_match_flag_a;
    logic overflow_flag;
  } flags_t;

  localparam ctrl_t  CTRL_RST  = 8'h00;
  localparam flags_t FLAGS_RST = 4'h0;

endpackage : timer16_pkg

// ### rtl/timer16_compare.sv
// 16-bit timer with normal and clear-on-match counting and two compare outputs.
// Assumes timer_tick and the acknowledge pulses come from logic on aclk.
`timescale 1ns/1ns

module timer16_compare #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  timer_tick,
  input  wire logic                  overflow_ack,
  input  wire logic                  match_a_ack,
  input  wire logic                  capture_ack,
  output      timer16_pkg::flags_t   flags,
  output      logic [1:0]            compare_pin_out,
  output      logic [1:0]            compare_pin_oe_n
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old_v;
    if (strb[0]) begin
      r[7:0] = data[7:0];
    end
    if (strb[1]) begin
      r[15:8] = data[15:8];
    end
    return r;
  endfunction : merge16

  // Action taken on the output state for one compare event
  function automatic logic act(input logic [1:0] com, input logic cur);
    logic r;
    r = cur;
    case (com)
      timer16_pkg::COM_NONE:   r = cur;
      timer16_pkg::COM_TOGGLE: r = ~cur;
      timer16_pkg::COM_CLEAR:  r = 1'b0;
      timer16_pkg::COM_SET:    r = 1'b1;
      default:                 r = cur;
    endcase
    return r;
  endfunction : act

  // ----------------------------------------------------------------
  // Register bus state
  // ----------------------------------------------------------------
  logic              aw_hold_ff;
  logic [7:0]        awaddr_ff;
  logic              w_hold_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  // ----------------------------------------------------------------
  // Timer state
  // ----------------------------------------------------------------
  timer16_pkg::ctrl_t  ctrl_ff;
  timer16_pkg::flags_t flags_ff;
  logic [15:0]         cnt_ff;
  logic [15:0]         cmp_a_ff;
  logic [15:0]         cmp_b_ff;
  logic [15:0]         capt_ff;
  logic [1:0]          state_ff;
  logic [2:0]          pend_ff;
  logic                block_ff;
  logic [1:0]          port_ff;
  logic [1:0]          dir_ff;
  logic [1:0]          pin_ff;

  logic                do_wr;
  logic                wr_ctrl;
  logic                wr_cnt;
  logic                wr_flags;
  logic                wr_port;
  logic                mapped_wr;
  logic                non_pwm;
  logic                ctc_a;
  logic                ctc_i;
  logic                match_a;
  logic                match_b;
  logic                match_i;
  logic                top_hit;
  logic                force_a;
  logic                force_b;
  logic [31:0]         rd_data;
  logic                rd_ok;
  timer16_pkg::flags_t flag_set;
  timer16_pkg::flags_t flag_clr;
  localparam int DIR_LSB_HI = timer16_pkg::DIR_LSB + 1;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
  assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  // Both halves held, so they may arrive in either order
  assign do_wr = aw_hold_ff && w_hold_ff && !bvalid_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      awaddr_ff  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr[7:0];
    end else if (do_wr) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_ff <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (do_wr) begin
      w_hold_ff <= 1'b0;
    end
  end

  assign wr_ctrl  = do_wr && (awaddr_ff == timer16_pkg::OFS_CTRL);
  assign wr_cnt   = do_wr && (awaddr_ff == timer16_pkg::OFS_COUNT);
  assign wr_flags = do_wr && (awaddr_ff == timer16_pkg::OFS_FLAGS);
  assign wr_port  = do_wr && (awaddr_ff == timer16_pkg::OFS_PORT);
  assign mapped_wr = wr_ctrl || wr_cnt || wr_flags || wr_port ||
                     (awaddr_ff == timer16_pkg::OFS_CMPA) ||
                     (awaddr_ff == timer16_pkg::OFS_CMPB) ||
                     (awaddr_ff == timer16_pkg::OFS_CAPT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= timer16_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= mapped_wr ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (s_axi_araddr[7:0])
      timer16_pkg::OFS_CTRL:  rd_data[7:0]  = ctrl_ff;
      timer16_pkg::OFS_COUNT: rd_data[15:0] = cnt_ff;
      timer16_pkg::OFS_CMPA:  rd_data[15:0] = cmp_a_ff;
      timer16_pkg::OFS_CMPB:  rd_data[15:0] = cmp_b_ff;
      timer16_pkg::OFS_CAPT:  rd_data[15:0] = capt_ff;
      timer16_pkg::OFS_FLAGS: rd_data[3:0]  = flags_ff;
      timer16_pkg::OFS_PORT:  rd_data[5:0]  = {state_ff, dir_ff, port_ff};
      default:                rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= timer16_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_data;
      rresp_ff  <= rd_ok ? timer16_pkg::RESP_OKAY : timer16_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= timer16_pkg::CTRL_RST;
    end else if (wr_ctrl && wstrb_ff[0]) begin
      // Mode bits act from the next cycle; no shadow copy
      ctrl_ff <= wdata_ff[7:0];
    end
  end

  // Top registers are written straight through
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_ff <= timer16_pkg::ZERO16;
      cmp_b_ff <= timer16_pkg::ZERO16;
      capt_ff  <= timer16_pkg::ZERO16;
    end else if (do_wr) begin
      if (awaddr_ff == timer16_pkg::OFS_CMPA) begin
        cmp_a_ff <= merge16(cmp_a_ff, wdata_ff, wstrb_ff);
      end
      if (awaddr_ff == timer16_pkg::OFS_CMPB) begin
        cmp_b_ff <= merge16(cmp_b_ff, wdata_ff, wstrb_ff);
      end
      if (awaddr_ff == timer16_pkg::OFS_CAPT) begin
        capt_ff <= merge16(capt_ff, wdata_ff, wstrb_ff);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_ff <= 2'b00;
      dir_ff  <= 2'b00;
    end else if (wr_port && wstrb_ff[0]) begin
      port_ff <= wdata_ff[1:0];
      dir_ff  <= wdata_ff[DIR_LSB_HI:timer16_pkg::DIR_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Mode decode only; compare modes never reach the count path
  assign ctc_a   = (ctrl_ff.waveform_mode_select == timer16_pkg::WGM_CTC_A);
  assign ctc_i   = (ctrl_ff.waveform_mode_select == timer16_pkg::WGM_CTC_I);
  assign non_pwm = ctc_a || ctc_i ||
                   (ctrl_ff.waveform_mode_select == timer16_pkg::WGM_NORMAL);

  // Equality only, so a top set below the count is passed by
  assign match_a = (cnt_ff == cmp_a_ff) && !block_ff;
  assign match_b = (cnt_ff == cmp_b_ff) && !block_ff;
  assign match_i = ctc_i && (cnt_ff == capt_ff) && !block_ff;
  assign top_hit = (ctc_a && match_a) || match_i;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= timer16_pkg::ZERO16;
    end else if (wr_cnt) begin
      cnt_ff <= merge16(cnt_ff, wdata_ff, wstrb_ff);
    end else if (timer_tick) begin
      if (top_hit) begin
        cnt_ff <= timer16_pkg::ZERO16;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // Block lasts until a tick has passed, even if the timer is stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_ff <= 1'b0;
    end else if (wr_cnt) begin
      block_ff <= 1'b1;
    end else if (timer_tick) begin
      block_ff <= 1'b0;
    end
  end

  // Matches held one tick before they land
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_ff <= 3'b000;
    end else if (timer_tick) begin
      pend_ff <= {match_i, match_b, match_a};
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  always_comb begin
    flag_set = timer16_pkg::FLAGS_RST;
    flag_set.overflow_flag = timer_tick && !wr_cnt &&
                             (cnt_ff == timer16_pkg::CNT_MAX);
    flag_set.compare_match_flag_a = timer_tick && pend_ff[0];
    flag_set.compare_match_flag_b = timer_tick && pend_ff[1];
    flag_set.capture_flag = timer_tick && pend_ff[2];
    flag_clr = timer16_pkg::FLAGS_RST;
    if (wr_flags && wstrb_ff[0]) begin
      flag_clr = wdata_ff[3:0];
    end
    flag_clr.overflow_flag = flag_clr.overflow_flag || overflow_ack;
    flag_clr.compare_match_flag_a = flag_clr.compare_match_flag_a || match_a_ack;
    flag_clr.capture_flag = flag_clr.capture_flag || capture_ack;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= timer16_pkg::FLAGS_RST;
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | flag_set;
    end
  end

  assign flags = flags_ff;

  // ----------------------------------------------------------------
  // Compare output states
  // ----------------------------------------------------------------
  // Force touches only the states: no flag, no counter change
  assign force_a = wr_ctrl && wstrb_ff[1] && wdata_ff[timer16_pkg::FORCE_A_BIT] && non_pwm;
  assign force_b = wr_ctrl && wstrb_ff[1] && wdata_ff[timer16_pkg::FORCE_B_BIT] && non_pwm;

  // PWM polarity handling is not built here; those modes hold the states
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= 2'b00;
    end else begin
      if (force_a || (timer_tick && pend_ff[0] && non_pwm)) begin
        state_ff[0] <= act(ctrl_ff.compare_output_mode_a, state_ff[0]);
      end
      if (force_b || (timer_tick && pend_ff[1] && non_pwm)) begin
        state_ff[1] <= act(ctrl_ff.compare_output_mode_b, state_ff[1]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // State updates regardless of direction, so it is ready on enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_ff <= 2'b00;
    end else begin
      pin_ff[0] <= (ctrl_ff.compare_output_mode_a != timer16_pkg::COM_NONE) ? state_ff[0] : port_ff[0];
      pin_ff[1] <= (ctrl_ff.compare_output_mode_b != timer16_pkg::COM_NONE) ? state_ff[1] : port_ff[1];
    end
  end

  assign compare_pin_out  = pin_ff;
  assign compare_pin_oe_n = ~dir_ff;

endmodule : timer16_compare

// ### verification/timer16_compare_props.sv
// Port checker for the 16-bit compare timer.
// Assumes one aclk domain; bound to every timer16_compare instance.
`timescale 1ns/1ns

module timer16_compare_props (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                timer_tick,
  input wire logic                overflow_ack,
  input wire timer16_pkg::flags_t flags,
  input wire logic [1:0]          compare_pin_out,
  input wire logic [1:0]          compare_pin_oe_n
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_clear_a: assert property (!$past(aresetn) |-> flags == 4'h0 && compare_pin_out == 2'h0)
    else $error("outputs not cleared by reset");
  ovf_on_tick_a: assert property ($rose(flags.overflow_flag) |-> $past(timer_tick))
    else $error("overflow flag set without a tick");
  match_on_tick_a: assert property ($rose(flags.compare_match_flag_a) |-> $past(timer_tick))
    else $error("match flag set without a tick");
  capt_on_tick_a: assert property ($rose(flags.capture_flag) |-> $past(timer_tick))
    else $error("capture flag set without a tick");
  ovf_ack_a: assert property (overflow_ack && !timer_tick |=> !flags.overflow_flag)
    else $error("overflow flag kept after service");
  ovf_sticky_a: assert property ($fell(flags.overflow_flag) |-> $past(overflow_ack) || s_axi_bvalid)
    else $error("overflow flag cleared by counting");
  // State moves on ticks or forces; source moves on writes
  pin_source_a: assert property ($changed(compare_pin_out) |->
      $past(timer_tick, 2) || s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pin changed without tick or write");
  dir_only_a: assert property ($changed(compare_pin_oe_n) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin direction changed without a write");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  ovf_seen_c: cover property ($rose(flags.overflow_flag));
  match_seen_c: cover property ($rose(flags.compare_match_flag_a));
  capt_seen_c: cover property ($rose(flags.capture_flag));
  pin_toggle_c: cover property ($changed(compare_pin_out[0]) && !compare_pin_oe_n[0]);
endmodule : timer16_compare_props

bind timer16_compare timer16_compare_props u_props (
  .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .timer_tick, .overflow_ack, .flags, .compare_pin_out, .compare_pin_oe_n
);

// ### verification/timer16_compare_test.sv
// Self-checking bench for the 16-bit compare timer over AXI4-Lite.
// Assumes the bench alone drives every input; timer_tick is pulsed on demand.
`timescale 1ns/1ns

module timer16_compare_test;
  logic        aclk, aresetn, timer_tick, overflow_ack, match_a_ack, capture_ack;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, st;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_got, rresp_got, compare_pin_out, compare_pin_oe_n, m;
  logic [1:0]  modes [7] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3};
  timer16_pkg::flags_t flags;
  int          n_errors, compares, cyc;
  localparam logic [7:0] CT = timer16_pkg::OFS_CTRL, CN = timer16_pkg::OFS_COUNT;
  localparam logic [7:0] CA = timer16_pkg::OFS_CMPA, CP = timer16_pkg::OFS_CAPT, CB = timer16_pkg::OFS_CMPB;
  localparam logic [7:0] FL = timer16_pkg::OFS_FLAGS, PT = timer16_pkg::OFS_PORT;

  timer16_compare #(.ADDR_W(8)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_tick, .overflow_ack, .match_a_ack, .capture_ack, .flags, .compare_pin_out, .compare_pin_oe_n
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b1;
    w  = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    bresp_got = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rresp_got = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask : rdc

  // One-cycle prescaled tick with a gap, so N is 1 per pulse
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge aclk) timer_tick <= 1'b1;
      @(posedge aclk) timer_tick <= 1'b0;
    end
    @(posedge aclk);
  endtask : ticks

  task automatic ack(input logic [2:0] k);
    @(posedge aclk) {capture_ack, match_a_ack, overflow_ack} <= k;
    @(posedge aclk) {capture_ack, match_a_ack, overflow_ack} <= 3'h0;
    @(posedge aclk);
  endtask : ack

  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    {aresetn, timer_tick, overflow_ack, match_a_ack, capture_ack} = 5'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h0;
    s_axi_wstrb  = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(CT, 32'h0);
    rdc(PT, 32'h0);
    chk(flags, 32'h0);
    chk(compare_pin_oe_n, 32'h3);
    $display("test reset done");
    wr(PT, 32'h1);
    st = 1'b0;
    foreach (modes[i]) begin
      m = modes[i];
      wr(CT, {24'h0, 2'h0, m, 4'h0});
      rdc(PT, {26'h0, 1'b0, st, 4'h1});
      wr(CT, {22'h0, 1'b0, 1'b1, 2'h0, m, 4'h0});
      st = (m == 2'h1) ? ~st : (m == 2'h2) ? 1'b0 : (m == 2'h3) ? 1'b1 : st;
      rdc(PT, {26'h0, 1'b0, st, 4'h1});
      chk(compare_pin_out[0], (m != 2'h0) ? st : 1'b1);
    end
    chk(flags, 32'h0);
    rdc(CN, 32'h0);
    wr(PT, 32'h5);
    rdc(PT, 32'h15);
    chk(compare_pin_oe_n, 32'h2);
    wr(CT, 32'hc0);
    wr(CT, 32'h2c0);
    rdc(PT, 32'h35);
    chk(compare_pin_out, 32'h3);
    wr(CT, 32'h80);
    wr(CT, 32'h280);
    rdc(PT, 32'h15);
    $display("test force done");
    wr(CA, 32'h1000);
    wr(CN, 32'hfffe);
    ticks(1);
    rdc(CN, 32'hffff);
    chk(flags, 32'h0);
    ticks(1);
    rdc(CN, 32'h0);
    chk(flags, 32'h1);
    ticks(2);
    chk(flags, 32'h5);
    ack(3'h1);
    chk(flags, 32'h4);
    wr(CB, 32'h8000);
    wr(FL, 32'h4);
    chk(flags, 32'h0);
    wr(CA, 32'h5);
    wr(CN, 32'h5);
    ticks(3);
    chk(flags, 32'h0);
    wr(CN, 32'h4);
    ticks(3);
    chk(flags, 32'h2);
    rdc(CN, 32'h7);
    wr(FL, 32'h2);
    chk(flags, 32'h0);
    $display("test normal done");
    wr(CT, 32'h14);
    wr(CA, 32'h3);
    wr(CN, 32'h0);
    ticks(5);
    rdc(CN, 32'h1);
    chk(flags, 32'h2);
    rdc(PT, 32'h05);
    ticks(4);
    rdc(PT, 32'h15);
    ticks(4);
    rdc(PT, 32'h05);
    chk(compare_pin_out[0], 32'h0);
    ack(3'h2);
    chk(flags, 32'h0);
    wr(CN, 32'hfffd);
    ticks(3);
    rdc(CN, 32'h0);
    chk(flags, 32'h1);
    ticks(4);
    rdc(CN, 32'h0);
    wr(CA, 32'h1);
    ticks(2);
    rdc(CN, 32'h0);
    wr(FL, 32'hf);
    chk(flags, 32'h0);
    wr(CT, 32'hc);
    wr(CP, 32'h2);
    wr(CN, 32'h0);
    ticks(3);
    rdc(CN, 32'h0);
    ticks(1);
    chk(flags, 32'ha);
    ack(3'h4);
    chk(flags, 32'h2);
    $display("test clear on match done");
    wr(8'h1c, 32'h1);
    chk(bresp_got, timer16_pkg::RESP_SLVERR);
    rd(8'h1c);
    chk(rresp_got, timer16_pkg::RESP_SLVERR);
    chk(rdat, 32'h0);
    $display("test unmapped done");
    summarize();
  end
endmodule : timer16_compare_test
